// ==== bench/lci_cpu_model.sv ====
// Processor arbitration and interrupt answer.
// Assumes it is the only level-6 requester; lag slows the grant.
`include "lci_defs.svh"
module lci_cpu_model (
	input wire logic		clock,
	input wire logic		reset_n,
	input wire logic		bus_br6,
	input wire logic		bus_sack,
	input wire logic		bus_intr,
	input wire logic		bus_data_oe,
	input wire logic [15:0]	bus_data_out,
	input wire logic [3:0]	lag,
	output logic			grant_level6_in,
	output logic			bus_ssyn_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_reg <= 4'h0;
			grant_level6_in <= 1'b0;
			bus_ssyn_in <= 1'b0;
		end else begin
			wait_reg <= bus_br6 ? wait_reg + 4'h1 : 4'h0;
			grant_level6_in <= !bus_sack && (grant_level6_in || bus_br6 && wait_reg >= lag);
			bus_ssyn_in <= bus_intr && bus_data_oe && bus_data_out == `LCI_VECTOR;
		end
	end
endmodule

// ==== bench/lci_line_clock_props.sv ====
// Port checker for the line clock block.
// Assumes bus inputs change away from the rising clock edge.
`include "lci_defs.svh"
module lci_line_clock_props (
	input wire logic		clock,
	input wire logic		reset_n,
	input wire logic [17:0]	bus_addr,
	input wire logic		bus_msyn,
	input wire logic		bus_ssyn_in,
	input wire logic		bus_bbsy_in,
	input wire logic		grant_level6_in,
	input wire logic		grant_level6_out,
	input wire logic		bus_br6,
	input wire logic		bus_sack,
	input wire logic		bus_bbsy_out,
	input wire logic		bus_intr,
	input wire logic		bus_ssyn_out,
	input wire logic [15:0]	bus_data_out,
	input wire logic		bus_data_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	wire sel = bus_msyn && (bus_addr | 18'h1) == (`LCI_ADDR_WORD | 18'h1);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_gnt; bus_br6 && grant_level6_in |=> bus_sack && !bus_br6; endproperty
	a_gnt: assert property (p_gnt) else $error("grant not taken");
	property p_blk; grant_level6_out |-> grant_level6_in && !bus_br6 && !bus_sack; endproperty
	a_blk: assert property (p_blk) else $error("grant passed on");
	property p_mst; bus_sack && !grant_level6_in && !bus_ssyn_in && !bus_bbsy_in
		|=> bus_intr && bus_bbsy_out && !bus_sack; endproperty
	a_mst: assert property (p_mst) else $error("no mastership");
	property p_bsy; bus_sack && bus_bbsy_in |=> !bus_intr; endproperty
	a_bsy: assert property (p_bsy) else $error("master while busy");
	property p_vec; $rose(bus_intr) |=> bus_data_oe && bus_data_out == `LCI_VECTOR; endproperty
	a_vec: assert property (p_vec) else $error("vector missing");
	property p_end; bus_intr && bus_ssyn_in |=> !(bus_intr || bus_bbsy_out || bus_sack); endproperty
	a_end: assert property (p_end) else $error("no release");
	property p_ack; $rose(sel) |-> !bus_ssyn_out ##[4:6] bus_ssyn_out; endproperty
	a_ack: assert property (p_ack) else $error("slave sync late");
	property p_sel; !sel |-> !bus_ssyn_out; endproperty
	a_sel: assert property (p_sel) else $error("unselected answer");
endmodule
bind lci_line_clock lci_line_clock_props lci_line_clock_props_i (.*);

// ==== bench/lci_line_clock_test.sv ====
// Bench for the line clock block: register rows, then interrupt cases.
// Assumes the processor model answers every vector.
`include "lci_defs.svh"
module lci_line_clock_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clock = 0, reset_n = 0, line_pulse_in = 0, bus_c1 = 0, bus_msyn = 0;
	logic		bus_bbsy_in = 0, grant_level6_in, bus_ssyn_in, grant_level6_out, bus_br6;
	logic		bus_sack, bus_bbsy_out, bus_intr, bus_ssyn_out, bus_data_oe;
	logic [17:0]	bus_addr = 0;
	logic [15:0]	bus_data_in = 0, bus_data_out, q;
	logic [3:0]	lag = 0;
	logic [31:0]	rows [4] = '{32'h0040_0040, 32'h0000_0000, 32'hffbf_0000, 32'hffff_0040};
	int		fails = 0, tests_run = 0, n;
	lci_line_clock lci_line_clock_i (.*);
	lci_cpu_model lci_cpu_model_i (.*);
	initial forever #10 clock = ~clock;
	task cmp(input string s, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task xfer(input logic w, input logic [17:0] a, input logic [15:0] d, input logic ex);
		{bus_c1, bus_addr, bus_data_in, bus_msyn} = {w, a, d, 1'b1};
		n = 0;
		do begin
			@(posedge clock);
			#1;
		end while (bus_ssyn_out !== 1 && ++n < 12);
		q = bus_data_out;
		cmp("ssyn", 16'(ex), 16'(n < 12));
		if (ex && n == 12) complete_run();
		// Master sync stays up through the edge that samples slave sync high.
		@(posedge clock);
		#2 bus_msyn = 0;
		@(posedge clock);
		#2;
	endtask
	task wait_intr(input int w);
		n = 0;
		do @(posedge clock); while (bus_intr !== 1 && ++n < w);
		#2;
	endtask
	task pulse(input int w);
		line_pulse_in = 1;
		repeat (4) @(posedge clock);
		#2 line_pulse_in = 0;
		wait_intr(w);
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#2 reset_n = 1;
		foreach (rows[i]) begin
			xfer(1, `LCI_ADDR_WORD, rows[i][31:16], 1);
			xfer(0, `LCI_ADDR_WORD | 18'h1, 0, 1);
			cmp("status", rows[i][15:0], q);
		end
		xfer(1, `LCI_ADDR_WORD, 0, 1);
		pulse(12);
		cmp("no_intr", 0, 16'(n < 12));
		xfer(0, `LCI_ADDR_WORD, 0, 1);
		cmp("monitor", 16'h0080, q);
		xfer(1, `LCI_ADDR_WORD, 16'h00c0, 1);
		xfer(0, `LCI_ADDR_WORD, 0, 1);
		cmp("cleared", 16'h0040, q);
		{lag, bus_bbsy_in} = {4'h3, 1'b1};
		pulse(16);
		cmp("bbsy_wait", 0, 16'(n < 16));
		bus_bbsy_in = 0;
		wait_intr(8);
		cmp("intr", 1, 16'(n < 8));
		repeat (4) @(posedge clock);
		#2 cmp("idle", 0, 16'({bus_br6, bus_sack, bus_intr, bus_bbsy_out}));
		xfer(0, `LCI_ADDR_WORD, 0, 1);
		cmp("monitor", 16'h00c0, q);
		xfer(0, `LCI_ADDR_WORD + 18'h2, 0, 0);
		reset_n = 0;
		#20 reset_n = 1;
		xfer(0, `LCI_ADDR_WORD, 0, 1);
		cmp("init", 0, q);
		complete_run();
	end
endmodule

// ==== hw/lci_defs.svh ====
// Constants for the line clock interrupt and status block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LCI_DEFS_SVH
`define LCI_DEFS_SVH

`define LCI_ADDR_WORD      18'o777546
`define LCI_VECTOR         16'o000100
`define LCI_BIT_ENABLE     6
`define LCI_BIT_MONITOR    7
`define LCI_SSYN_DELAY_NS  100
`define LCI_CLK_PERIOD_NS  20

`endif

// ==== hw/lci_line_clock.sv ====
// Line clock interrupt request and two-bit status register on the system bus.
// Assumes bus inputs are synchronous to clock; bus outputs are asserted-high levels.
`include "lci_defs.svh"

// Summary of operation
// R1: Idle: all flip-flops clear, nothing driven.
// R2: Pulse sets request only when enabled.
// R3: Request without grant drives level-6 request.
// R4: Grant latches, blocks passing, drops request.
// R5: Grant latched, not master: assert select acknowledge.
// R6: Become master when grant, sync, busy clear.
// R7: Master drives busy, interrupt, vector 100.
// R8: Slave sync clears request and both latches in the same cycle.
// R9: Processor grants level 6 only if highest.
// R10: Processor drops grant on select acknowledge.
// R11: Processor answers with sync, takes vector.
// R12: Initialize clears enable and monitor bits.
// R13: Every pulse sets monitor bit.
// R14: Selected write with data bit 7 clears monitor.
// R15: Access needs address match with master sync.
// R16: Slave sync follows selection after fixed delay.
// R17: Selected write loads enable from bit 6.
// R18: Enable clear forces request clear while awaiting grant.
// R19: Selected read returns enable and monitor bits.
// R20: Fixed word address, byte bit ignored.
// R21: Line pulse synchronised and edge detected.
module lci_line_clock
	import lci_pkg::*;
#(
	parameter int SSYN_CYCLES = (`LCI_SSYN_DELAY_NS + `LCI_CLK_PERIOD_NS - 1) / `LCI_CLK_PERIOD_NS
)(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        line_pulse_in,
	input  wire logic [17:0] bus_addr,
	input  wire logic        bus_c1,
	input  wire logic        bus_msyn,
	input  wire logic        bus_ssyn_in,
	input  wire logic        bus_bbsy_in,
	input  wire logic [15:0] bus_data_in,
	input  wire logic        grant_level6_in,
	output logic             grant_level6_out,
	output logic             bus_br6,
	output logic             bus_sack,
	output logic             bus_bbsy_out,
	output logic             bus_intr,
	output logic             bus_ssyn_out,
	output logic [15:0]      bus_data_out,
	output logic             bus_data_oe
);

	// ****************************************
	// Line pulse detection
	// ****************************************
	// The first stage feeds only the second; the edge detector looks at later stages.
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	wire  line_event = sync2_reg & ~sync3_reg; // R21

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= line_pulse_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// ****************************************
	// Address selection and slave sync
	// ****************************************
	// The low address bit is left out of the compare so both bytes hit the word.
	wire addr_hit  = (bus_addr[17:1] == `LCI_ADDR_WORD >> 1); // R20
	wire selected  = addr_hit & bus_msyn; // R15
	wire is_write  = bus_c1;
	logic [7:0] delay_reg;
	logic [7:0] delay_next;
	logic       done_reg;
	logic       enable_reg;
	logic       monitor_reg;

	wire  delay_done = (delay_reg == 8'(SSYN_CYCLES));
	assign delay_next = !selected ? 8'h00 : (delay_done ? delay_reg : delay_reg + 8'h01);
	wire  strobe     = selected & delay_done & ~done_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			delay_reg <= 8'h00;
			done_reg  <= 1'b0;
		end else begin
			delay_reg <= delay_next;
			done_reg  <= selected & delay_done;
		end
	end

	// ****************************************
	// Status register
	// ****************************************
	// Write acts once per bus cycle, on the cycle the slave sync first rises.
	wire wr_strobe = strobe & is_write;
	wire enable_next = wr_strobe ? bus_data_in[`LCI_BIT_ENABLE] : enable_reg; // R17
	// A new pulse wins over a clearing write in the same cycle.
	wire monitor_next = line_event ? 1'b1 : // R13
		((wr_strobe & bus_data_in[`LCI_BIT_MONITOR]) ? 1'b0 : monitor_reg); // R14

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			enable_reg  <= 1'b0; // R12
			monitor_reg <= 1'b0; // R12
		end else begin
			enable_reg  <= enable_next;
			monitor_reg <= monitor_next;
		end
	end

	// ****************************************
	// Interrupt control
	// ****************************************
	lci_state_t state_reg;
	lci_state_t state_next;
	logic       request_ff;
	logic       grant_latch_ff;
	logic       master_latch_ff;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LCI_IDLE: begin
				if (line_event && enable_reg) begin
					state_next = LCI_REQUEST; // R2
				end
			end
			LCI_REQUEST: begin
				if (grant_level6_in) begin
					state_next = LCI_GRANTED; // R4
				end
			end
			LCI_GRANTED: begin
				if (!grant_level6_in && !bus_ssyn_in && !bus_bbsy_in) begin
					state_next = LCI_MASTER; // R6
				end
			end
			LCI_MASTER: begin
				if (bus_ssyn_in) begin
					state_next = LCI_IDLE; // R8
				end
			end
			default: state_next = LCI_IDLE;
		endcase
		if (!enable_reg && (state_reg == LCI_REQUEST)) begin
			state_next = LCI_IDLE; // R18
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= LCI_IDLE; // R1
		end else begin
			state_reg <= state_next;
		end
	end

	assign request_ff      = (state_reg != LCI_IDLE);
	assign grant_latch_ff  = state_reg[2] | state_reg[3];
	assign master_latch_ff = state_reg[3];

	// ****************************************
	// Bus outputs
	// ****************************************
	// The grant passes downstream only when this block is not requesting.
	assign grant_level6_out = grant_level6_in & ~request_ff; // R4
	assign bus_br6          = request_ff & ~grant_latch_ff; // R3
	assign bus_sack         = grant_latch_ff & ~master_latch_ff; // R5
	assign bus_bbsy_out     = master_latch_ff; // R7
	assign bus_intr         = master_latch_ff; // R7
	assign bus_ssyn_out     = selected & delay_done; // R16

	logic [15:0] data_reg;
	logic        oe_reg;
	wire  rd_sel = selected & ~is_write;
	wire [15:0] rd_word = {8'h00, monitor_reg, enable_reg, 6'h00}; // R19
	wire [15:0] data_next = master_latch_ff ? `LCI_VECTOR : (rd_sel ? rd_word : 16'h0000); // R7

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			data_reg <= 16'h0000;
			oe_reg   <= 1'b0;
		end else begin
			data_reg <= data_next;
			oe_reg   <= master_latch_ff | rd_sel;
		end
	end

	assign bus_data_out = data_reg;
	assign bus_data_oe  = oe_reg;

endmodule

// ==== hw/lci_pkg.sv ====
// Types for the line clock interrupt and status block.
// Assumes the constants header sits beside it.
`include "lci_defs.svh"

package lci_pkg;

	typedef enum logic [3:0] {
		LCI_IDLE    = 4'b0001,
		LCI_REQUEST = 4'b0010,
		LCI_GRANTED = 4'b0100,
		LCI_MASTER  = 4'b1000
	} lci_state_t;

endpackage
